// [rtl/dtod_pkg.sv]
// Shared types and constants for the data-transfer opcode decoder.
// Assumes one 40 MHz clock; all counts are in clock cycles.
package dtod_pkg;

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE       = 5'h00,
    OP_ACC_TO_MEM = 5'h01, // Accumulator stored at direct address
    OP_LOAD_SEG   = 5'h02, // Segment register loaded from reg/mem
    OP_STORE_SEG  = 5'h03, // Segment register copied to reg/mem
    OP_PUSH_MEM   = 5'h04,
    OP_PUSH_REG   = 5'h05,
    OP_PUSH_SEG   = 5'h06,
    OP_PUSH_IMM   = 5'h07,
    OP_PUSH_ALL   = 5'h08, // stack_store_all_op
    OP_POP_MEM    = 5'h09,
    OP_POP_REG    = 5'h0a,
    OP_POP_SEG    = 5'h0b,
    OP_POP_ALL    = 5'h0c, // stack_load_all_op
    OP_SWAP_RM    = 5'h0d, // swap_operands_op, register with reg/mem
    OP_SWAP_ACC   = 5'h0e, // swap_operands_op, register with accumulator
    OP_IN_FIX     = 5'h0f,
    OP_IN_VAR     = 5'h10,
    OP_OUT_FIX    = 5'h11,
    OP_OUT_VAR    = 5'h12,
    OP_TABLE_LOOKUP_BYTE_OP_BYTE  = 5'h13  // table_lookup_byte_op
  } dtod_op_e;

  // Sequencer states, Gray along idle -> fetch -> exec
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b11
  } dtod_state_e;

  // Result of decoding the first opcode byte
  typedef struct packed {
    dtod_op_e   op;    // Operation class
    logic       wide;  // Word operation when set
    logic       modrm; // Addressing byte follows
    logic [1:0] imm;   // Fixed operand bytes after opcode
    logic [2:0] sel;   // Register or segment select
    logic       bad;   // Not a form this block handles
  } dtod_dec_s;

  // ----------------------------------------------------------------
  // Execution cycle counts
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_ACC_STORE = 5'h03;
  localparam logic [4:0] CNT_LSEG_REG_R = 5'h02;
  localparam logic [4:0] CNT_LSEG_MEM_R = 5'h05;
  localparam logic [4:0] CNT_LSEG_REG_P = 5'h11;
  localparam logic [4:0] CNT_LSEG_MEM_P = 5'h13;
  localparam logic [4:0] CNT_SSEG_REG = 5'h02;
  localparam logic [4:0] CNT_SSEG_MEM = 5'h03;
  localparam logic [4:0] CNT_PUSH_MEM = 5'h05;
  localparam logic [4:0] CNT_PUSH = 5'h03;
  localparam logic [4:0] CNT_PUSH_ALL = 5'h11;
  localparam logic [4:0] CNT_POP = 5'h05;
  localparam logic [4:0] CNT_POP_SEG_P = 5'h14;
  localparam logic [4:0] CNT_POP_ALL = 5'h13;
  localparam logic [4:0] CNT_SWAP_REG = 5'h03;
  localparam logic [4:0] CNT_SWAP_MEM = 5'h05;
  localparam logic [4:0] CNT_IN = 5'h05;
  localparam logic [4:0] CNT_OUT = 5'h03;
  localparam logic [4:0] CNT_TABLE_LOOKUP_BYTE_OP = 5'h05;

  // ----------------------------------------------------------------
  // Field codes and exception vectors
  // ----------------------------------------------------------------
  localparam logic [1:0] MOD_REG = 2'h3;      // Register operand form
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [2:0] RM_DIRECT = 3'h6;    // Direct address under mod 00
  localparam logic [2:0] SUB_PUSH_MEM = 3'h6;
  localparam logic [2:0] SUB_POP_MEM = 3'h0;
  localparam logic [1:0] SEG_NO_POP = 2'h1;   // Code segment cannot be popped
  localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
  localparam logic [7:0] VEC_STACK = 8'h0c;

endpackage

// [rtl/dtod_timer.sv]
// Execution cycle timer for the opcode decoder.
// Assumes load and abort are single-cycle strobes from the sequencer.
`timescale 1ns/1ps

module dtod_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic abort,
  input wire logic stall,
  input wire logic [4:0] count_in,
  output logic expire
);

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  logic [4:0] cnt_r; // Cycles left, zero when idle

  // Last cycle, unless a bus wait holds it back
  assign expire = (cnt_r == 5'h01) & ~stall;

  // Wait states stretch the count instead of being folded in up front
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 5'h00;
    end else if (ce) begin
      if (abort) begin
        cnt_r <= 5'h00;
      end else if (load) begin
        cnt_r <= count_in;
      end else if ((cnt_r != 5'h00) && !stall) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end

endmodule // dtod_timer

// [rtl/dtod_top.sv]
// Decoder and timer for the data-transfer opcode group.
// Assumes opcode bytes arrive one per cycle, synchronous to CLK.
`timescale 1ns/1ps

module dtod_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_IN,
  input wire logic PROT_MODE,
  input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
  input wire logic [1:0] IO_PRIVILEGE_THRESHOLD,
  input wire logic SEG_FAULT,
  input wire logic STACK_FAULT,
  input wire logic BUS_WAIT,
  output logic BYTE_READY,
  output logic BUSY,
  output logic OP_DONE,
  output logic [4:0] OP_CLASS,
  output logic OP_WIDE,
  output logic [2:0] REG_SEL,
  output logic REG_FORM,
  output logic BUS_HOLD,
  output logic EXC_RAISE,
  output logic [7:0] EXC_VECTOR,
  output logic ILLEGAL
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------

  // First byte: class, width and operand bytes still to come
  function automatic dtod_pkg::dtod_dec_s decode_first(input logic [7:0] b);
    dtod_pkg::dtod_dec_s d;
    d = '{op: dtod_pkg::OP_NONE, wide: 1'b1, modrm: 1'b0, imm: 2'h0,
          sel: b[2:0], bad: 1'b0};
    casez (b)
      8'b1010001?: begin d.op = dtod_pkg::OP_ACC_TO_MEM; d.wide = b[0]; d.imm = 2'h2; end
      8'b10001110: begin d.op = dtod_pkg::OP_LOAD_SEG; d.modrm = 1'b1; end
      8'b10001100: begin d.op = dtod_pkg::OP_STORE_SEG; d.modrm = 1'b1; end
      8'b11111111: begin d.op = dtod_pkg::OP_PUSH_MEM; d.modrm = 1'b1; end
      8'b01010???: d.op = dtod_pkg::OP_PUSH_REG;
      8'b000??110: begin d.op = dtod_pkg::OP_PUSH_SEG; d.sel = {1'b0, b[4:3]}; end
      8'b011010?0: begin d.op = dtod_pkg::OP_PUSH_IMM; d.imm = b[1] ? 2'h1 : 2'h2; end
      8'b01100000: d.op = dtod_pkg::OP_PUSH_ALL;
      8'b10001111: begin d.op = dtod_pkg::OP_POP_MEM; d.modrm = 1'b1; end
      8'b01011???: d.op = dtod_pkg::OP_POP_REG;
      8'b000??111: begin
        d.op = dtod_pkg::OP_POP_SEG;
        d.sel = {1'b0, b[4:3]};
        d.bad = (b[4:3] == dtod_pkg::SEG_NO_POP);
      end
      8'b01100001: d.op = dtod_pkg::OP_POP_ALL;
      8'b1000011?: begin d.op = dtod_pkg::OP_SWAP_RM; d.wide = b[0]; d.modrm = 1'b1; end
      8'b10010???: d.op = dtod_pkg::OP_SWAP_ACC;
      8'b1110010?: begin d.op = dtod_pkg::OP_IN_FIX; d.wide = b[0]; d.imm = 2'h1; end
      8'b1110110?: begin d.op = dtod_pkg::OP_IN_VAR; d.wide = b[0]; end
      8'b1110011?: begin d.op = dtod_pkg::OP_OUT_FIX; d.wide = b[0]; d.imm = 2'h1; end
      8'b1110111?: begin d.op = dtod_pkg::OP_OUT_VAR; d.wide = b[0]; end
      8'b11010111: begin d.op = dtod_pkg::OP_TABLE_LOOKUP_BYTE_OP_BYTE; d.wide = 1'b0; end
      default: d.bad = 1'b1; // Other groups are not handled here
    endcase
    return d;
  endfunction

  // Displacement bytes that follow an addressing byte
  function automatic logic [1:0] disp_len(input logic [1:0] md, input logic [2:0] rm);
    if (md == dtod_pkg::MOD_DISP8) return 2'h1;
    if (md == dtod_pkg::MOD_DISP16) return 2'h2;
    if ((md == 2'h0) && (rm == dtod_pkg::RM_DIRECT)) return 2'h2;
    return 2'h0;
  endfunction

  // Execution cycles: register form takes the smaller figure
  function automatic logic [4:0] clocks_for(input dtod_pkg::dtod_op_e op,
                                            input logic rf, input logic prot);
    unique case (op)
      dtod_pkg::OP_ACC_TO_MEM: return dtod_pkg::CNT_ACC_STORE;
      dtod_pkg::OP_LOAD_SEG: begin
        if (prot) return rf ? dtod_pkg::CNT_LSEG_REG_P : dtod_pkg::CNT_LSEG_MEM_P;
        return rf ? dtod_pkg::CNT_LSEG_REG_R : dtod_pkg::CNT_LSEG_MEM_R;
      end
      dtod_pkg::OP_STORE_SEG: return rf ? dtod_pkg::CNT_SSEG_REG : dtod_pkg::CNT_SSEG_MEM;
      dtod_pkg::OP_PUSH_MEM: return dtod_pkg::CNT_PUSH_MEM;
      dtod_pkg::OP_PUSH_ALL: return dtod_pkg::CNT_PUSH_ALL;
      dtod_pkg::OP_POP_SEG: return prot ? dtod_pkg::CNT_POP_SEG_P : dtod_pkg::CNT_POP;
      dtod_pkg::OP_POP_ALL: return dtod_pkg::CNT_POP_ALL;
      dtod_pkg::OP_SWAP_RM: return rf ? dtod_pkg::CNT_SWAP_REG : dtod_pkg::CNT_SWAP_MEM;
      dtod_pkg::OP_SWAP_ACC: return dtod_pkg::CNT_SWAP_REG;
      dtod_pkg::OP_POP_MEM, dtod_pkg::OP_POP_REG: return dtod_pkg::CNT_POP;
      dtod_pkg::OP_IN_FIX, dtod_pkg::OP_IN_VAR: return dtod_pkg::CNT_IN;
      dtod_pkg::OP_OUT_FIX, dtod_pkg::OP_OUT_VAR: return dtod_pkg::CNT_OUT;
      dtod_pkg::OP_TABLE_LOOKUP_BYTE_OP_BYTE: return dtod_pkg::CNT_TABLE_LOOKUP_BYTE_OP;
      default: return dtod_pkg::CNT_PUSH; // Other pushes
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dtod_pkg::dtod_state_e state_r, state_nxt; // Sequencer
  dtod_pkg::dtod_dec_s dec_r, dec_nxt;       // Instruction in hand
  logic [1:0] rem_r, rem_nxt;                // Operand bytes left
  logic pend_r, pend_nxt;                    // Addressing byte awaited
  logic rf_r, rf_nxt;                        // Register operand form
  logic prot_r;                              // Mode caught at exec start
  logic [4:0] exec_cnt_r;                    // Exec cycles seen, for checks

  // ----------------------------------------------------------------
  // Decode wires
  // ----------------------------------------------------------------
  dtod_pkg::dtod_dec_s first_dec;
  dtod_pkg::dtod_op_e op_now;
  logic take, idle_take, fetch_take, modrm_err, bad_take, go_last;
  logic io_op, io_deny, enter_exec, io_trap, rf_now;
  logic stack_op, mem_op, in_exec, stack_hit, fault_hit, tmr_expire;
  logic [1:0] mod_f, disp;
  logic [2:0] reg_f;
  logic [4:0] clocks;

  assign take = CE & BYTE_VALID & BYTE_READY;
  assign idle_take = take & (state_r == dtod_pkg::ST_IDLE);
  assign fetch_take = take & (state_r == dtod_pkg::ST_FETCH);
  assign first_dec = decode_first(BYTE_IN);
  assign mod_f = BYTE_IN[7:6];
  assign reg_f = BYTE_IN[5:3];
  assign disp = disp_len(mod_f, BYTE_IN[2:0]);
  assign op_now = (state_r == dtod_pkg::ST_IDLE) ? first_dec.op : dec_r.op;

  // Sub-field checks on the addressing byte
  assign modrm_err = pend_r & (
    ((dec_r.op == dtod_pkg::OP_PUSH_MEM) & (reg_f != dtod_pkg::SUB_PUSH_MEM)) |
    ((dec_r.op == dtod_pkg::OP_POP_MEM) & (reg_f != dtod_pkg::SUB_POP_MEM)) |
    (((dec_r.op == dtod_pkg::OP_LOAD_SEG) | (dec_r.op == dtod_pkg::OP_STORE_SEG)) & reg_f[2]));
  assign bad_take = (idle_take & first_dec.bad) | (fetch_take & modrm_err);

  // Last byte of the instruction has just been taken
  assign go_last = (idle_take & ~first_dec.bad & ~first_dec.modrm & (first_dec.imm == 2'h0)) |
                   (fetch_take & ~modrm_err & (pend_r ? (disp == 2'h0) : (rem_r == 2'h1)));

  // Port access checked before any cycle is spent
  assign io_op = (op_now == dtod_pkg::OP_IN_FIX) | (op_now == dtod_pkg::OP_IN_VAR) |
                 (op_now == dtod_pkg::OP_OUT_FIX) | (op_now == dtod_pkg::OP_OUT_VAR);
  assign io_deny = PROT_MODE & io_op &
                   (CURRENT_PRIVILEGE_LEVEL > IO_PRIVILEGE_THRESHOLD);
  assign io_trap = go_last & io_deny;
  assign enter_exec = go_last & ~io_deny;

  // Register form only when the addressing byte says mod 11
  assign rf_now = pend_r ? (mod_f == dtod_pkg::MOD_REG) : rf_r;
  assign clocks = clocks_for(op_now, rf_now, PROT_MODE);

  // Operand faults, protected mode only; stack overrun outranks the rest
  assign in_exec = state_r == dtod_pkg::ST_EXEC;
  assign stack_op = (dec_r.op >= dtod_pkg::OP_PUSH_MEM) & (dec_r.op <= dtod_pkg::OP_POP_ALL);
  assign mem_op = (dec_r.op == dtod_pkg::OP_ACC_TO_MEM) | (dec_r.op == dtod_pkg::OP_TABLE_LOOKUP_BYTE_OP_BYTE) |
                  (~rf_r & ((dec_r.op == dtod_pkg::OP_LOAD_SEG) |
                  (dec_r.op == dtod_pkg::OP_STORE_SEG) | (dec_r.op == dtod_pkg::OP_PUSH_MEM) |
                  (dec_r.op == dtod_pkg::OP_POP_MEM) | (dec_r.op == dtod_pkg::OP_SWAP_RM)));
  assign stack_hit = STACK_FAULT & stack_op;
  assign fault_hit = in_exec & prot_r & (stack_hit | (SEG_FAULT & mem_op));

  // ----------------------------------------------------------------
  // Execution timer
  // ----------------------------------------------------------------
  dtod_timer u_timer (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .load(enter_exec),
    .abort(fault_hit),
    .stall(BUS_WAIT),
    .count_in(clocks),
    .expire(tmr_expire)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    dec_nxt = dec_r;
    rem_nxt = rem_r;
    pend_nxt = pend_r;
    rf_nxt = rf_r;
    unique case (state_r)
      dtod_pkg::ST_IDLE: begin
        if (idle_take) begin
          // Opcode byte: remember it and what must follow
          dec_nxt = first_dec;
          pend_nxt = first_dec.modrm;
          rem_nxt = first_dec.imm;
          rf_nxt = 1'b0;
          if (enter_exec) state_nxt = dtod_pkg::ST_EXEC;
          else if (!(first_dec.bad || go_last)) state_nxt = dtod_pkg::ST_FETCH;
        end
      end
      dtod_pkg::ST_FETCH: begin
        if (fetch_take) begin
          if (pend_r) begin
            // Addressing byte: form, select and displacement length
            pend_nxt = 1'b0;
            rf_nxt = rf_now;
            rem_nxt = disp;
            if (dec_r.op != dtod_pkg::OP_PUSH_MEM && dec_r.op != dtod_pkg::OP_POP_MEM) begin
              dec_nxt.sel = reg_f;
            end
          end else begin
            rem_nxt = rem_r - 2'h1;
          end
          if (enter_exec) state_nxt = dtod_pkg::ST_EXEC;
          else if (bad_take || go_last) state_nxt = dtod_pkg::ST_IDLE;
        end
      end
      dtod_pkg::ST_EXEC: begin
        // Fault aborts at once; otherwise leave on the last counted cycle
        if (fault_hit || tmr_expire) state_nxt = dtod_pkg::ST_IDLE;
      end
      default: state_nxt = dtod_pkg::ST_IDLE; // Unused code recovers
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= dtod_pkg::ST_IDLE;
      dec_r <= '0;
      rem_r <= 2'h0;
      pend_r <= 1'b0;
      rf_r <= 1'b0;
    end else if (CE) begin
      state_r <= state_nxt;
      dec_r <= dec_nxt;
      rem_r <= rem_nxt;
      pend_r <= pend_nxt;
      rf_r <= rf_nxt;
    end
  end

  // Mode held for the whole execution, and a cycle tally for checks
  always_ff @(posedge CLK) begin
    if (RST) begin
      prot_r <= 1'b0;
      exec_cnt_r <= 5'h00;
    end else if (CE) begin
      if (enter_exec) begin
        prot_r <= PROT_MODE;
        exec_cnt_r <= 5'h00;
      end else if (in_exec && !BUS_WAIT && !fault_hit) begin
        exec_cnt_r <= exec_cnt_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      BYTE_READY <= 1'b1;
      BUSY <= 1'b0;
      OP_DONE <= 1'b0;
      BUS_HOLD <= 1'b0;
      EXC_RAISE <= 1'b0;
      EXC_VECTOR <= 8'h00;
      ILLEGAL <= 1'b0;
    end else if (CE) begin
      BYTE_READY <= state_nxt != dtod_pkg::ST_EXEC;
      BUSY <= state_nxt != dtod_pkg::ST_IDLE;
      OP_DONE <= in_exec & tmr_expire & ~fault_hit;
      // Locked bus for the whole memory swap, prefix or not
      BUS_HOLD <= (state_nxt == dtod_pkg::ST_EXEC) &
                  (dec_nxt.op == dtod_pkg::OP_SWAP_RM) & ~rf_nxt;
      EXC_RAISE <= io_trap | fault_hit;
      if (io_trap || fault_hit) begin
        EXC_VECTOR <= (fault_hit && stack_hit) ? dtod_pkg::VEC_STACK : dtod_pkg::VEC_GEN_PROT;
      end
      ILLEGAL <= bad_take;
    end
  end

  // Instruction fields come straight from the held decode
  assign OP_CLASS = dec_r.op;
  assign OP_WIDE = dec_r.wide;
  assign REG_SEL = dec_r.sel;
  assign REG_FORM = rf_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_acc_store;
    OP_DONE && dec_r.op == dtod_pkg::OP_ACC_TO_MEM |-> exec_cnt_r == 5'h03;
  endproperty
  a_acc_store: assert property (p_acc_store) else $error("store length wrong");

  property p_load_seg;
    OP_DONE && dec_r.op == dtod_pkg::OP_LOAD_SEG |->
      exec_cnt_r == (prot_r ? (rf_r ? 5'h11 : 5'h13) : (rf_r ? 5'h02 : 5'h05));
  endproperty
  a_load_seg: assert property (p_load_seg) else $error("segment load length wrong");

  property p_push_imm;
    idle_take && BYTE_IN == 8'h6a |=> state_r == dtod_pkg::ST_FETCH && rem_r == 2'h1;
  endproperty
  a_push_imm: assert property (p_push_imm) else $error("short immediate miscounted");

  property p_push_all;
    OP_DONE && dec_r.op == dtod_pkg::OP_PUSH_ALL |-> exec_cnt_r == 5'h11;
  endproperty
  a_push_all: assert property (p_push_all) else $error("push all length wrong");

  property p_pop_seg_bad;
    idle_take && BYTE_IN == 8'h0f |=> ILLEGAL && !BUSY ##1 !ILLEGAL;
  endproperty
  a_pop_seg_bad: assert property (p_pop_seg_bad) else $error("invalid pop accepted");

  property p_pop_all;
    OP_DONE && dec_r.op == dtod_pkg::OP_POP_ALL |-> exec_cnt_r == 5'h13;
  endproperty
  a_pop_all: assert property (p_pop_all) else $error("pop all length wrong");

  property p_swap_rm;
    OP_DONE && dec_r.op == dtod_pkg::OP_SWAP_RM |-> exec_cnt_r == (rf_r ? 5'h03 : 5'h05);
  endproperty
  a_swap_rm: assert property (p_swap_rm) else $error("swap length wrong");

  property p_stack_fault;
    in_exec && CE && prot_r && STACK_FAULT && stack_op |=>
      EXC_RAISE && EXC_VECTOR == 8'h0c && !OP_DONE && !BUSY;
  endproperty
  a_stack_fault: assert property (p_stack_fault) else $error("stack fault missed");

  property p_io_deny;
    io_trap |=> EXC_RAISE && EXC_VECTOR == 8'h0d && !BUSY;
  endproperty
  a_io_deny: assert property (p_io_deny) else $error("port access not trapped");

  property p_bus_hold;
    in_exec && dec_r.op == dtod_pkg::OP_SWAP_RM && !rf_r |-> BUS_HOLD;
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("memory swap without hold");

  c_push_all: cover property (OP_DONE && dec_r.op == dtod_pkg::OP_PUSH_ALL);
  c_trap: cover property (EXC_RAISE && EXC_VECTOR == 8'h0d);
  c_hold_wait: cover property (BUS_HOLD && BUS_WAIT);
  c_illegal: cover property (ILLEGAL);

endmodule // dtod_top

// [bench/dtod_bus_model.sv]
// Bus-side model: wait states and fault levels seen by the decoder.
// Assumes BYTE_READY from the decoder is low exactly in execution cycles.
`timescale 1ns/1ps

module dtod_bus_model (
  input wire logic clk,
  input wire logic exec_n,
  input wire logic [1:0] waits,
  input wire logic seg_en,
  input wire logic stk_en,
  output logic bus_wait,
  output logic seg_fault,
  output logic stack_fault
);
  logic [1:0] used_r; // Wait cycles already given
  // Waits come first in execution, so the added count is exact
  assign bus_wait = !exec_n && (used_r < waits);
  // Faults only while an operation executes
  assign seg_fault = !exec_n && seg_en;
  assign stack_fault = !exec_n && stk_en;
  // Count of waits, cleared between operations
  always_ff @(posedge clk) begin
    if (exec_n) used_r <= 2'h0;
    else if (bus_wait) used_r <= used_r + 2'h1;
  end
endmodule // dtod_bus_model

// [bench/tb_data_transfer_opcode_decode.sv]
// Self-checking bench for the data-transfer opcode decoder.
// Assumes dtod_top and dtod_bus_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end

module tb_data_transfer_opcode_decode;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  typedef struct {logic [2:0] k; logic [7:0] op; logic [4:0] cl; int c; int n;
    logic [7:0] v;} dtod_note_s; // Expected event
  dtod_note_s q[$], nt;
  logic CLK = 0, RST = 1, BYTE_VALID = 0, PROT_MODE = 0, seg_en = 0, stk_en = 0, ce = 1;
  logic [7:0] BYTE_IN = 8'h00;
  logic [1:0] current_privilege_level = 2'h0, waits = 2'h0, io_privilege_threshold = 2'h1;
  logic BYTE_READY, BUSY, OP_DONE, OP_WIDE, REG_FORM, BUS_HOLD, EXC_RAISE, ILLEGAL;
  logic BUS_WAIT, SEG_FAULT, STACK_FAULT;
  logic [4:0] OP_CLASS;
  logic [2:0] REG_SEL;
  logic [7:0] EXC_VECTOR;
  int cyc = 0, tk = 0, err_total = 0, n_tests = 0, hold = 0;
  logic [31:0] rs = 32'h0000c93a; // Seed
  dtod_top uut (.CLK(CLK), .RST(RST), .CE(ce), .BYTE_VALID(BYTE_VALID), .BYTE_IN(BYTE_IN),
    .PROT_MODE(PROT_MODE), .CURRENT_PRIVILEGE_LEVEL(current_privilege_level), .IO_PRIVILEGE_THRESHOLD(io_privilege_threshold),
    .SEG_FAULT(SEG_FAULT), .STACK_FAULT(STACK_FAULT), .BUS_WAIT(BUS_WAIT),
    .BYTE_READY(BYTE_READY), .BUSY(BUSY), .OP_DONE(OP_DONE), .OP_CLASS(OP_CLASS),
    .OP_WIDE(OP_WIDE), .REG_SEL(REG_SEL), .REG_FORM(REG_FORM), .BUS_HOLD(BUS_HOLD),
    .EXC_RAISE(EXC_RAISE), .EXC_VECTOR(EXC_VECTOR), .ILLEGAL(ILLEGAL));
  dtod_bus_model bus (.clk(CLK), .exec_n(BYTE_READY), .waits(waits), .seg_en(seg_en),
    .stk_en(stk_en), .bus_wait(BUS_WAIT), .seg_fault(SEG_FAULT), .stack_fault(STACK_FAULT));
  // ----------------------------------------------------------------
  // Clock, cycle count and hang guard
  // ----------------------------------------------------------------
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 4000) begin
      err_total++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  // Hold one byte until an edge sees it ready
  task automatic send(input logic [7:0] b);
    BYTE_VALID = 1'b1;
    BYTE_IN = b;
    while (BYTE_READY !== 1'b1) @(posedge CLK) #1;
    @(posedge CLK) #1;
    tk = cyc;
  endtask
  // Whole operation, then its note: k is {done, exception, refused}
  task automatic op(input logic p, input logic [2:0] k, input logic [4:0] cl, input int n,
    input logic [7:0] v, input int nb, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00);
    logic [7:0] bs [3];
    bs = '{b0, b1, b2};
    PROT_MODE = p;
    for (int i = 0; i < nb; i++) send(bs[i]);
    q.push_back('{k, b0, cl, tk + n + waits, n, v});
  endtask
  // Stop offering bytes, let pending events land
  task automatic drain();
    BYTE_VALID = 1'b0;
    for (int i = 0; i < 60 && q.size() > 0; i++) @(posedge CLK) #1;
  endtask
  // ----------------------------------------------------------------
  // Monitor: oldest note against each event
  // ----------------------------------------------------------------
  always @(negedge CLK) begin
    if (!RST && BUS_HOLD === 1'b1) hold++;
    if (!RST && (OP_DONE | EXC_RAISE | ILLEGAL) === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      if (q.size() > 0) nt = q.pop_front();
      `CHK({OP_DONE, EXC_RAISE, ILLEGAL}, nt.k)
      `CHK(cyc, nt.c)
      `CHK({BUSY, BYTE_READY}, 2'b01)
      if (OP_DONE) begin
        `CHK(OP_CLASS, nt.cl)
        `CHK(hold, (nt.cl == 5'h0d && nt.n == 5) ? nt.n : 0)
        if (nt.cl == 5'h0d) `CHK(REG_FORM, nt.n == 3)
        if (nt.op[7:3] inside {5'h0a, 5'h0b, 5'h12}) `CHK(REG_SEL, nt.op[2:0])
        if (nt.op[7:1] inside {7'h51, 7'h43, 7'h72, 7'h76, 7'h73, 7'h77})
          `CHK(OP_WIDE, nt.op[0])
      end else if (EXC_RAISE) `CHK(EXC_VECTOR, nt.v)
      hold = 0;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge CLK);
    #1 RST = 1'b0;
    op(0, 3'h4, 5'h01, 3, 8'h00, 3, 8'ha3, rnd(), rnd());
    op(0, 3'h4, 5'h02, 2, 8'h00, 2, 8'h8e, 8'hd8);
    op(0, 3'h4, 5'h02, 5, 8'h00, 3, 8'h8e, 8'h5e, rnd());
    op(1, 3'h4, 5'h02, 17, 8'h00, 2, 8'h8e, 8'hd8);
    op(1, 3'h4, 5'h02, 19, 8'h00, 3, 8'h8e, 8'h5e, rnd());
    op(0, 3'h4, 5'h03, 2, 8'h00, 2, 8'h8c, 8'hc8);
    op(0, 3'h4, 5'h03, 3, 8'h00, 3, 8'h8c, 8'h46, rnd());
    op(0, 3'h4, 5'h04, 5, 8'h00, 3, 8'hff, 8'h76, rnd());
    op(0, 3'h4, 5'h05, 3, 8'h00, 1, 8'h50 | (rnd() & 8'h07));
    op(0, 3'h4, 5'h07, 3, 8'h00, 2, 8'h6a, rnd());
    op(0, 3'h4, 5'h07, 3, 8'h00, 3, 8'h68, rnd(), rnd());
    op(0, 3'h4, 5'h08, 17, 8'h00, 1, 8'h60);
    op(0, 3'h4, 5'h09, 5, 8'h00, 3, 8'h8f, 8'h46, rnd());
    op(0, 3'h4, 5'h0a, 5, 8'h00, 1, 8'h58 | (rnd() & 8'h07));
    op(1, 3'h4, 5'h0b, 20, 8'h00, 1, 8'h1f);
    op(0, 3'h1, 5'h00, 0, 8'h00, 1, 8'h0f);
    op(0, 3'h4, 5'h0c, 19, 8'h00, 1, 8'h61);
    op(0, 3'h4, 5'h0d, 3, 8'h00, 2, 8'h87, 8'hc3);
    op(0, 3'h4, 5'h0d, 5, 8'h00, 2, 8'h86, 8'h07);
    op(0, 3'h4, 5'h0e, 3, 8'h00, 1, 8'h90 | (rnd() & 8'h07));
    op(1, 3'h4, 5'h0f, 5, 8'h00, 2, 8'he4, rnd());
    op(1, 3'h4, 5'h10, 5, 8'h00, 1, 8'hed);
    op(0, 3'h4, 5'h11, 3, 8'h00, 2, 8'he7, rnd());
    op(0, 3'h4, 5'h12, 3, 8'h00, 1, 8'hee);
    op(0, 3'h4, 5'h13, 5, 8'h00, 1, 8'hd7);
    op(0, 3'h1, 5'h00, 0, 8'h00, 2, 8'hff, 8'h00);
    current_privilege_level = 2'h3;
    op(1, 3'h2, 5'h00, 0, 8'h0d, 1, 8'hec);
    drain();
    io_privilege_threshold = 2'h3; // Same level as the threshold passes
    op(1, 3'h4, 5'h12, 3, 8'h00, 1, 8'hef);
    drain();
    {current_privilege_level, io_privilege_threshold} = 4'h1;
    stk_en = 1'b1;
    op(1, 3'h2, 5'h00, 1, 8'h0c, 1, 8'h50);
    drain();
    {stk_en, seg_en} = 2'b01;
    op(1, 3'h2, 5'h00, 1, 8'h0d, 1, 8'hd7);
    drain();
    {seg_en, waits} = 3'b010;
    op(0, 3'h4, 5'h13, 5, 8'h00, 1, 8'hd7);
    drain();
    waits = 2'h0;
    op(0, 3'h4, 5'h0c, 21, 8'h00, 1, 8'h61);
    ce = 1'b0; // Two frozen edges stretch the count
    repeat (2) @(posedge CLK) #1;
    ce = 1'b1;
    drain();
    end_sim();
  end
  // Report and stop
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule // tb_data_transfer_opcode_decode
